// >>> rtl/gnss_group_pkg.sv
package gnss_group_pkg;

   // ****************************************
   // field selection
   // ****************************************
   localparam int        MASK_WIDTH     = 16;
   localparam int        FIXED_FIELDS   = 14;
   localparam int        MAX_BYTES      = 28;
   localparam int        FIELD_BITS     = 8 * MAX_BYTES;
   localparam logic [3:0] SEL_CIVIL_TIME = 4'h0;
   localparam logic [3:0] SEL_FIX        = 4'h4;
   localparam logic [3:0] SEL_TIME_BLOCK = 4'hc;
   localparam logic [3:0] SEL_LAST_FIXED = 4'hd;
   localparam logic [4:0] FIELD_LEN [0:13] = '{
      5'h08, 5'h08, 5'h02, 5'h01, 5'h01, 5'h18, 5'h18,
      5'h0c, 5'h0c, 5'h0c, 5'h04, 5'h04, 5'h02, 5'h1c};

   // ****************************************
   // encodings and counts
   // ****************************************
   localparam logic [15:0] YEAR_BASE      = 16'h07d0;
   localparam int          TOW_VALID_BIT  = 0;
   localparam int          WEEK_VALID_BIT = 1;
   localparam int          CIVIL_VALID_BIT = 2;
   localparam int          FIFO_DEPTH     = 16;
   localparam int          DIV_WIDTH      = 16;

   typedef enum logic [1:0] {
      FIX_NONE      = 2'b00,
      FIX_TIME_ONLY = 2'b01,
      FIX_2D        = 2'b10,
      FIX_3D        = 2'b11
   } fix_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEEK = 2'b01,
      ST_SEND = 2'b10
   } walk_state_type;

   typedef struct packed {
      logic [15:0]        year;
      logic [7:0]         month;
      logic [7:0]         day;
      logic [7:0]         hour;
      logic [7:0]         minute;
      logic [7:0]         second;
      logic [15:0]        millis;
      logic [63:0]        towNs;
      logic [15:0]        week;
      logic [7:0]         trackedSatelliteCount;
      fix_type            fix;
      logic [2:0][63:0]   geodeticPosition;
      logic [2:0][63:0]   earthFixedPosition;
      logic [2:0][31:0]   localFrameVelocity;
      logic [2:0][31:0]   earthFixedVelocity;
      logic [2:0][31:0]   positionSigma;
      logic [31:0]        velocitySigma;
      logic [31:0]        timeSigma;
      logic               weekTimeValidFlag;
      logic               weekNumberValidFlag;
      logic               civilTimeValidFlag;
      logic signed [7:0]  leapSecondCount;
      logic [6:0][31:0]   precisionDilutionSet;
   } solution_type;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } stream_word_type;

endpackage : gnss_group_pkg

// >>> rtl/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid_reg,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData_reg
);
   localparam int AW = $clog2(DEPTH);

   // ****************************************
   // storage and pointers
   // ****************************************
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   logic             pushFire;
   logic             popFire;
   logic             empty;

   assign inReady  = (count_reg != (AW+1)'(DEPTH));
   assign empty    = (count_reg == '0);
   assign pushFire = inValid && inReady;
   // output stage refills only when drained, so back-pressure reaches us
   assign popFire  = !empty && (!outValid_reg || outReady);

   always_ff @(posedge clk) begin
      if (pushFire) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_reg    <= '0;
         rdPtr_reg    <= '0;
         count_reg    <= '0;
         outValid_reg <= 1'b0;
         outData_reg  <= '0;
      end else begin
         if (pushFire) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (popFire) begin
            rdPtr_reg   <= rdPtr_reg + 1'b1;
            outData_reg <= mem[rdPtr_reg];
         end
         count_reg <= count_reg + (AW+1)'(pushFire) - (AW+1)'(popFire);
         if (popFire) begin
            outValid_reg <= 1'b1;
         end else if (outReady) begin
            outValid_reg <= 1'b0;
         end
      end
   end

endmodule : stream_fifo

// >>> rtl/rate_divider.sv
`timescale 1ns/1ps
module rate_divider
   import gnss_group_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 sampleTick,
   input  wire logic [DIV_WIDTH-1:0] divisor,
   output logic                      pulse_reg
);
   logic [DIV_WIDTH-1:0] count_reg;
   logic                 wrap;

   // a divisor of zero behaves as one
   assign wrap = (count_reg + 1'b1 >= divisor);

   always_ff @(posedge clk) begin
      if (srst) begin
         count_reg <= '0;
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= sampleTick && wrap;
         if (sampleTick) begin
            count_reg <= wrap ? '0 : count_reg + 1'b1;
         end
      end
   end

endmodule : rate_divider

// >>> rtl/gnss_group_framer.sv
`timescale 1ns/1ps
// Behaviour
// - fields refresh only on new receiver solution
// - emit on update, else on divided sample rate
// - mask bits 0..13 select fields in order, bits 14 and 15 ignored
// - year sent as signed offset from 2000
// - civil time eight bytes, milliseconds at six
// - time of week is 64-bit nanoseconds
// - week number is unsigned 16 bits
// - tracked satellite count is one byte
// - fix byte codes 0 to 3
// - geodetic position three doubles, 24 bytes
// - earth-fixed position in meters, three doubles
// - local-frame velocity three floats, 12 bytes
// - earth-fixed velocity three floats
// - position sigma three floats
// - velocity sigma one float
// - time sigma one four-byte float
// - time block: status byte, signed leap count
// - status bits 0..2 validity, rest reserved
// - seven dilution floats, 28 bytes, fixed order
module gnss_group_framer
   import gnss_group_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire solution_type          solutionIn,
   input  wire logic                  solutionStrobe,
   input  wire logic [MASK_WIDTH-1:0] fieldMask,
   input  wire logic                  rateMatchesGnss,
   input  wire logic                  imuSampleTick,
   input  wire logic [DIV_WIDTH-1:0]  rateDivisor,
   output logic [7:0]                 streamData_reg,
   output logic                       streamLast_reg,
   output logic                       streamValid_reg,
   input  wire logic                  streamReady,
   output logic                       busy_reg,
   output logic                       overrun_reg
);

   // ****************************************
   // solution store and frame copy
   // ****************************************
   solution_type       store_reg;
   solution_type       frame_reg;
   logic               gnssUpdate_reg;
   logic               divPulse;
   logic               trigger;
   logic               startFrame;
   logic [13:0]        mask_reg;
   logic [13:0]        maskNext;

   always_ff @(posedge clk) begin
      if (srst) begin
         store_reg      <= '0;
         gnssUpdate_reg <= 1'b0;
      end else begin
         gnssUpdate_reg <= solutionStrobe;
         if (solutionStrobe) begin
            store_reg <= solutionIn;
         end
      end
   end

   rate_divider u_div (
      .clk        (clk),
      .srst       (srst),
      .sampleTick (imuSampleTick),
      .divisor    (rateDivisor),
      .pulse_reg  (divPulse)
   );

   // ****************************************
   // emission pacing
   // ****************************************
   walk_state_type state_reg;
   walk_state_type stateNext;

   assign trigger    = rateMatchesGnss ? gnssUpdate_reg : divPulse;
   // fields 14 and 15 are variable length and never framed here
   assign maskNext   = fieldMask[13:0];
   assign startFrame = trigger && (state_reg == ST_IDLE) && (|maskNext);

   // ****************************************
   // field images, least significant byte first
   // ****************************************
   logic [FIELD_BITS-1:0] fieldVec [0:FIXED_FIELDS-1];
   logic [7:0]            yearOffset;
   logic [7:0]            statusByte;

   assign yearOffset = 8'(frame_reg.year - YEAR_BASE);
   assign statusByte = {5'h00,
                        frame_reg.civilTimeValidFlag,
                        frame_reg.weekNumberValidFlag,
                        frame_reg.weekTimeValidFlag};

   assign fieldVec[0]  = FIELD_BITS'({frame_reg.millis,
                                      frame_reg.second,
                                      frame_reg.minute,
                                      frame_reg.hour,
                                      frame_reg.day,
                                      frame_reg.month,
                                      yearOffset});
   assign fieldVec[1]  = FIELD_BITS'(frame_reg.towNs);
   assign fieldVec[2]  = FIELD_BITS'(frame_reg.week);
   assign fieldVec[3]  =
      FIELD_BITS'(frame_reg.trackedSatelliteCount);
   assign fieldVec[4]  = FIELD_BITS'({6'h00, frame_reg.fix});
   assign fieldVec[5]  =
      FIELD_BITS'(frame_reg.geodeticPosition);
   assign fieldVec[6]  =
      FIELD_BITS'(frame_reg.earthFixedPosition);
   assign fieldVec[7]  =
      FIELD_BITS'(frame_reg.localFrameVelocity);
   assign fieldVec[8]  =
      FIELD_BITS'(frame_reg.earthFixedVelocity);
   assign fieldVec[9]  = FIELD_BITS'(frame_reg.positionSigma);
   assign fieldVec[10] = FIELD_BITS'(frame_reg.velocitySigma);
   assign fieldVec[11] = FIELD_BITS'(frame_reg.timeSigma);
   assign fieldVec[12] = FIELD_BITS'({frame_reg.leapSecondCount,
                                      statusByte});
   assign fieldVec[13] = frame_reg.precisionDilutionSet;

   // ****************************************
   // field walk
   // ****************************************
   logic [3:0]      fieldIdx_reg;
   logic [3:0]      fieldIdxNext;
   logic [4:0]      byteIdx_reg;
   logic [4:0]      byteIdxNext;
   logic [3:0]      safeIdx;
   logic [4:0]      curLen;
   logic [7:0]      curByte;
   logic [13:0]     maskAbove;
   logic            lastOfField;
   logic            lastByte;
   logic            fifoReady;
   logic            pushFire;
   stream_word_type pushWord;
   stream_word_type outWord;

   function automatic logic [13:0] above_mask(input logic [13:0] m,
                                              input logic [3:0]  i);
      above_mask = m & 14'(14'h3ffe << i);
   endfunction : above_mask

   assign safeIdx     = (fieldIdx_reg > SEL_LAST_FIXED) ?
                        SEL_LAST_FIXED : fieldIdx_reg;
   assign curLen      = FIELD_LEN[safeIdx];
   assign curByte     = fieldVec[safeIdx][8*byteIdx_reg +: 8];
   assign maskAbove   = above_mask(mask_reg, fieldIdx_reg);
   assign lastOfField = (byteIdx_reg == curLen - 5'h01);
   assign lastByte    = lastOfField && (maskAbove == 14'h0000);
   assign pushFire    = (state_reg == ST_SEND) && fifoReady;
   assign pushWord    = '{last: lastByte, data: curByte};

   always_comb begin
      stateNext    = state_reg;
      fieldIdxNext = fieldIdx_reg;
      byteIdxNext  = byteIdx_reg;
      case (state_reg)
         ST_IDLE: begin
            if (startFrame) begin
               stateNext    = ST_SEEK;
               fieldIdxNext = 4'h0;
            end
         end
         ST_SEEK: begin
            byteIdxNext = 5'h00;
            if (mask_reg[safeIdx]) begin
               stateNext = ST_SEND;
            end else begin
               fieldIdxNext = fieldIdx_reg + 4'h1;
            end
         end
         ST_SEND: begin
            if (fifoReady) begin
               if (lastByte) begin
                  stateNext = ST_IDLE;
               end else if (lastOfField) begin
                  stateNext    = ST_SEEK;
                  byteIdxNext  = 5'h00;
                  fieldIdxNext = fieldIdx_reg + 4'h1;
               end else begin
                  byteIdxNext = byteIdx_reg + 5'h01;
               end
            end
         end
         default: begin
            stateNext = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg    <= ST_IDLE;
         fieldIdx_reg <= 4'h0;
         byteIdx_reg  <= 5'h00;
         mask_reg     <= 14'h0000;
         frame_reg    <= '0;
         busy_reg     <= 1'b0;
         overrun_reg  <= 1'b0;
      end else begin
         state_reg    <= stateNext;
         fieldIdx_reg <= fieldIdxNext;
         byteIdx_reg  <= byteIdxNext;
         busy_reg     <= (stateNext != ST_IDLE);
         // a trigger during a frame is dropped, not queued
         overrun_reg  <= trigger && (state_reg != ST_IDLE);
         if (startFrame) begin
            mask_reg  <= maskNext;
            frame_reg <= store_reg;
         end
      end
   end

   // ****************************************
   // output buffer
   // ****************************************
   stream_fifo #(
      .WIDTH ($bits(stream_word_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk          (clk),
      .srst         (srst),
      .inValid      (state_reg == ST_SEND),
      .inReady      (fifoReady),
      .inData       (pushWord),
      .outValid_reg (streamValid_reg),
      .outReady     (streamReady),
      .outData_reg  (outWord)
   );

   assign streamData_reg = outWord.data;
   assign streamLast_reg = outWord.last;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_store_hold: assert property (
      !solutionStrobe |=> $stable(store_reg))
      else $error("solution store changed without strobe");

   chk_gnss_pace: assert property (
      state_reg == ST_IDLE && rateMatchesGnss && gnssUpdate_reg
      && (|fieldMask[13:0]) |=> state_reg == ST_SEEK ##1 busy_reg)
      else $error("receiver update did not start a frame");

   chk_idle_quiet: assert property (
      state_reg == ST_IDLE && !trigger |=> state_reg == ST_IDLE)
      else $error("frame started without a trigger");

   chk_send_selected: assert property (
      state_reg == ST_SEND |-> mask_reg[fieldIdx_reg]
      && fieldIdx_reg <= SEL_LAST_FIXED)
      else $error("unselected field being sent");

   chk_year_base: assert property (
      pushFire && fieldIdx_reg == SEL_CIVIL_TIME && byteIdx_reg == 5'h00
      |-> pushWord.data == 8'(frame_reg.year - YEAR_BASE))
      else $error("year offset wrong");

   chk_civil_len: assert property (
      state_reg == ST_SEND && fieldIdx_reg == SEL_CIVIL_TIME
      |-> byteIdx_reg <= 5'h07)
      else $error("civil time field too long");

   chk_fix_range: assert property (
      pushFire && fieldIdx_reg == SEL_FIX |-> pushWord.data <= 8'h03)
      else $error("fix code out of range");

   chk_status_resv: assert property (
      pushFire && fieldIdx_reg == SEL_TIME_BLOCK && byteIdx_reg == 5'h00
      |-> pushWord.data[7:3] == 5'h00)
      else $error("reserved status bits set");

   chk_field_step: assert property (
      pushFire && lastOfField && !lastByte
      |=> state_reg == ST_SEEK
      && fieldIdx_reg == $past(fieldIdx_reg) + 4'h1 && byteIdx_reg == 0)
      else $error("field order broken");

   chk_overrun_flag: assert property (
      trigger && state_reg != ST_IDLE |=> overrun_reg)
      else $error("dropped trigger not flagged");

   chk_frame_end: assert property (
      pushFire && lastByte |=> state_reg == ST_IDLE && !busy_reg)
      else $error("frame did not end after last byte");

   chk_byte_bound: assert property (
      state_reg == ST_SEND |-> byteIdx_reg < curLen)
      else $error("byte index past field length");

   chk_copy_hold: assert property (
      state_reg != ST_IDLE |=> $stable(frame_reg))
      else $error("frame copy changed mid frame");

endmodule : gnss_group_framer

// >>> dv/host_sink.sv
`timescale 1ns/1ps
// ****************************************
// host side byte sink
// ****************************************
module host_sink
   import gnss_group_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] streamData,
   input  wire logic       streamLast,
   input  wire logic       streamValid,
   input  wire logic       slowMode,
   output logic            streamReady
);
   stream_word_type rxq [$];
   int              packets = 0;
   logic [1:0]      phase_reg;

   // slow mode takes one byte in four, so the fifo backs up
   always_ff @(posedge clk) begin
      phase_reg   <= srst ? 2'h0 : phase_reg + 2'h1;
      streamReady <= !srst && (!slowMode || phase_reg == 2'h3);
   end

   // bytes kept in arrival order, fields parsed by ascending bit
   always @(posedge clk) begin
      if (!srst && streamValid && streamReady) begin
         rxq.push_back('{last: streamLast, data: streamData});
         if (streamLast) packets++;
      end
   end
endmodule : host_sink

// >>> dv/tb_gnss_group_framer.sv
`timescale 1ns/1ps
module tb_gnss_group_framer
   import gnss_group_pkg::*;
;
   logic            clk             = 1'b0;
   logic            srst            = 1'b1;
   solution_type    solutionIn      = '0;
   logic            solutionStrobe  = 1'b0;
   logic [15:0]     fieldMask       = 16'h0000;
   logic            rateMatchesGnss = 1'b1;
   logic            imuSampleTick   = 1'b0;
   logic [15:0]     rateDivisor     = 16'h0001;
   logic            slowMode        = 1'b0;
   logic [7:0]      streamData;
   logic            streamLast;
   logic            streamValid;
   logic            streamReady;
   logic            busy;
   logic            overrun;
   int              fails           = 0;
   int              total_checks    = 0;
   stream_word_type expq [$];

   always #50 clk = ~clk;

   gnss_group_framer u_dut (
      .clk(clk), .srst(srst), .solutionIn(solutionIn),
      .solutionStrobe(solutionStrobe), .fieldMask(fieldMask),
      .rateMatchesGnss(rateMatchesGnss), .imuSampleTick(imuSampleTick),
      .rateDivisor(rateDivisor), .streamData_reg(streamData),
      .streamLast_reg(streamLast), .streamValid_reg(streamValid),
      .streamReady(streamReady), .busy_reg(busy), .overrun_reg(overrun));

   host_sink u_host (
      .clk(clk), .srst(srst), .streamData(streamData),
      .streamLast(streamLast), .streamValid(streamValid),
      .slowMode(slowMode), .streamReady(streamReady));

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input string what, input logic [8:0] expv,
                        input logic [8:0] got);
      total_checks++;
      if (got !== expv) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
      end
   endtask : check

   task automatic add(input logic [7:0] b);
      expq.push_back('{last: 1'b0, data: b});
   endtask : add

   task automatic add16(input logic [15:0] v);
      add(v[7:0]);
      add(v[15:8]);
   endtask : add16

   task automatic add32(input logic [31:0] v);
      add16(v[15:0]);
      add16(v[31:16]);
   endtask : add32

   task automatic add64(input logic [63:0] v);
      add32(v[31:0]);
      add32(v[63:32]);
   endtask : add64

   // fields 14 and 15 are variable length and never sent
   task automatic build_exp(input solution_type s, input logic [15:0] m);
      expq.delete();
      if (m[0]) begin
         add(8'(s.year - YEAR_BASE));
         add(s.month);
         add(s.day);
         add(s.hour);
         add(s.minute);
         add(s.second);
         add16(s.millis);
      end
      if (m[1]) add64(s.towNs);
      if (m[2]) add16(s.week);
      if (m[3]) add(s.trackedSatelliteCount);
      if (m[4]) add({6'h00, s.fix});
      if (m[5]) for (int i = 0; i < 3; i++) add64(s.geodeticPosition[i]);
      if (m[6]) for (int i = 0; i < 3; i++) add64(s.earthFixedPosition[i]);
      if (m[7]) for (int i = 0; i < 3; i++) add32(s.localFrameVelocity[i]);
      if (m[8]) for (int i = 0; i < 3; i++) add32(s.earthFixedVelocity[i]);
      if (m[9]) for (int i = 0; i < 3; i++) add32(s.positionSigma[i]);
      if (m[10]) add32(s.velocitySigma);
      if (m[11]) add32(s.timeSigma);
      if (m[12]) begin
         add({5'h00, s.civilTimeValidFlag, s.weekNumberValidFlag,
              s.weekTimeValidFlag});
         add(s.leapSecondCount);
      end
      if (m[13]) for (int i = 0; i < 7; i++) add32(s.precisionDilutionSet[i]);
      if (expq.size() > 0) expq[$].last = 1'b1;
   endtask : build_exp

   // distinct bytes everywhere so a swapped or shifted byte shows
   task automatic make_sol(input logic [7:0] seed, output solution_type s);
      s = '0;
      for (int i = 0; i < $bits(solution_type) / 8; i++)
         s[8*i +: 8] = 8'(i * 13) + seed;
      s.year = 16'h07dd;
      s.fix  = FIX_3D;
   endtask : make_sol

   task automatic setup(input logic [15:0] m, input logic g,
                        input logic [15:0] d, input logic slow);
      @(posedge clk);
      fieldMask       <= m;
      rateMatchesGnss <= g;
      rateDivisor     <= d;
      slowMode        <= slow;
   endtask : setup

   task automatic strobe(input solution_type s);
      @(posedge clk);
      solutionIn     <= s;
      solutionStrobe <= 1'b1;
      @(posedge clk);
      solutionStrobe <= 1'b0;
   endtask : strobe

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         imuSampleTick <= 1'b1;
         @(posedge clk);
         imuSampleTick <= 1'b0;
      end
   endtask : ticks

   task automatic quiet(input string what);
      repeat (20) @(posedge clk);
      check(what, 9'h000, 9'(u_host.rxq.size()));
   endtask : quiet

   task automatic take_packet(input string what);
      int k;
      k = 0;
      while (u_host.packets == 0 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      #1;
      check({what, " count"}, 9'h001, 9'(u_host.packets));
      check({what, " length"}, 9'(expq.size()), 9'(u_host.rxq.size()));
      foreach (expq[i])
         if (i < u_host.rxq.size()) check(what, expq[i], u_host.rxq[i]);
      u_host.rxq.delete();
      u_host.packets = 0;
   endtask : take_packet

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_fix_codes();
      solution_type s;
      setup(16'h0010, 1'b1, 16'h0001, 1'b0);
      for (int c = 0; c < 4; c++) begin
         make_sol(8'(c), s);
         s.fix = fix_type'(c);
         build_exp(s, 16'h0010);
         strobe(s);
         take_packet("fix byte");
      end
      $display("test fix codes done");
   endtask : test_fix_codes

   // full mask with bits 14 and 15 set, slow sink fills the fifo
   task automatic test_full_group();
      solution_type s;
      setup(16'hffff, 1'b1, 16'h0001, 1'b1);
      make_sol(8'h5a, s);
      build_exp(s, 16'h3fff);
      strobe(s);
      take_packet("full");
      $display("test full group done");
   endtask : test_full_group

   task automatic test_time_fields();
      solution_type s;
      setup(16'h1001, 1'b1, 16'h0001, 1'b0);
      for (int c = 0; c < 2; c++) begin
         make_sol(8'h33, s);
         s.leapSecondCount     = 8'hee;
         s.weekTimeValidFlag   = (c == 0);
         s.weekNumberValidFlag = (c == 1);
         s.civilTimeValidFlag  = (c == 0);
         build_exp(s, 16'h1001);
         strobe(s);
         take_packet("civil time and status");
      end
      $display("test time fields done");
   endtask : test_time_fields

   // store only changes on the strobe; divided ticks pace output
   task automatic test_divided_pacing();
      solution_type s;
      solution_type s2;
      make_sol(8'h21, s);
      make_sol(8'h77, s2);
      setup(16'h0004, 1'b0, 16'h0003, 1'b0);
      strobe(s);
      quiet("no packet on strobe");
      ticks(2);
      quiet("no packet before count");
      build_exp(s, 16'h0004);
      ticks(1);
      take_packet("divided packet");
      @(posedge clk);
      solutionIn <= s2;
      ticks(3);
      take_packet("held solution");
      strobe(s2);
      build_exp(s2, 16'h0004);
      ticks(3);
      take_packet("refreshed solution");
      $display("test divided pacing done");
   endtask : test_divided_pacing

   // a second update mid frame is dropped; frame keeps its copy
   task automatic test_overrun();
      solution_type s;
      solution_type s2;
      int           seen;
      make_sol(8'h44, s);
      make_sol(8'h99, s2);
      seen = 0;
      setup(16'h2000, 1'b1, 16'h0001, 1'b0);
      build_exp(s, 16'h2000);
      strobe(s);
      strobe(s2);
      repeat (4) begin
         @(posedge clk);
         #1;
         if (overrun === 1'b1) seen++;
      end
      check("overrun pulse", 9'h001, 9'(seen));
      take_packet("frame copy");
      quiet("dropped trigger");
      $display("test overrun done");
   endtask : test_overrun

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   initial begin
      #(100ns * 20000);
      fails++;
      $display("watchdog expired");
      test_done();
   end

   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check("idle outputs", 9'h000, {6'h00, streamValid, busy, overrun});
      test_fix_codes();
      test_full_group();
      test_time_fields();
      test_divided_pacing();
      test_overrun();
      test_done();
   end
endmodule : tb_gnss_group_framer
